// *** video_out_overlay_pkg.sv ***
// shared constants for the overlay and buffer control block
package video_out_overlay_pkg;
    // register word indexes, byte address is four times the index
    localparam logic [3:0] IDX_ORIGIN = 4'h0;
    localparam logic [3:0] IDX_SIZE = 4'h1;
    localparam logic [3:0] IDX_ADDR1 = 4'h2;
    localparam logic [3:0] IDX_ADDR2 = 4'h3;
    localparam logic [3:0] IDX_ADDR3 = 4'h4;
    localparam logic [3:0] IDX_OVL_ADDR = 4'h5;
    localparam logic [3:0] IDX_CHROMA_PITCH = 4'h6;
    localparam logic [3:0] IDX_LUMA_PITCH = 4'h7;
    localparam logic [3:0] IDX_CTL = 4'h8;
    localparam logic [3:0] IDX_MASK = 4'h9;
    localparam logic [3:0] IDX_KEY = 4'hA;
    localparam logic [3:0] IDX_LIMITS = 4'hB;
    // field positions: origin and size registers
    localparam int POS_LSB = 0;
    localparam int POS_W = 12;
    localparam int LINE_LSB = 12;
    localparam int ALPHA_LSB = 24;
    // pitch halves, buffer length width
    localparam int PITCH_W = 16;
    localparam int HI_LSB = 16;
    localparam int LEN_W = 24;
    // enhancement control bits
    localparam int CTL_EN = 0;
    localparam int CTL_FULL = 1;
    localparam int CTL_CLIP = 2;
    localparam int CTL_STREAM = 3;
    localparam int CTL_FIELD = 4;
    localparam int CTL_GENLOCK = 5;
    localparam int CTL_KEY = 6;
    localparam int CTL_W = 7;
    localparam int REV_LSB = 28;
    // arbitrary revision value, not tied to any part
    localparam logic [3:0] REVISION = 4'h3;
    // mask and key / limit byte lanes
    localparam int CHROMA_COMPARE_MASK_LSB = 4;
    localparam int B0 = 0;
    localparam int B1 = 8;
    localparam int B2 = 16;
    localparam int B3 = 24;
    // fixed legacy limits and programmable defaults
    localparam logic [7:0] DEF_LO = 8'h10;
    localparam logic [7:0] DEF_HI = 8'hF0;
    localparam logic [31:0] LIMITS_RST = 32'hF010_EB10;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    // transfer modes from the main output control
    localparam logic [1:0] MODE_REFRESH = 2'h0;
    localparam logic [1:0] MODE_STREAM = 2'h1;
    localparam logic [1:0] MODE_MESSAGE = 2'h2;
    // component select codes
    localparam logic [1:0] COMP_Y = 2'h0;
    // full weight of a blend and rounding offset of the coarse levels
    localparam logic [8:0] W_FULL = 9'h100;
    localparam logic [8:0] W_ROUND = 9'h020;
endpackage : video_out_overlay_pkg

// *** video_out_overlay_buffer_control.sv ***
// overlay, keying, clipping, sync pin and buffer control of video output
// Notes on behaviour
// - overlay begins at programmed pixel offset
// - alpha bit picks set or clear blend
// - first address is luma or buffer1
// - second address is Cb or buffer2
// - third address is Cr or length1
// - overlay address or second buffer length
// - each pointer steps by own pitch
// - enable off means legacy behaviour
// - fine blending else five levels
// - custom limits else fixed 16 and 240
// - stream qualifier drives frame sync pin
// - frame sync pin follows field number
// - genlock needs bit set, master clear
// - key match makes overlay pixel transparent
// - revision in top four control bits
// - all enhancements off after reset
// - masks drop low key compare bits
// - programmable luma floor and ceiling clip
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module video_out_overlay_buffer_control
    import video_out_overlay_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // register bus
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // main output control and timing
    input wire logic [1:0] XFER_MODE,
    input wire logic SYNC_MASTER,
    input wire logic FIELD_START,
    input wire logic LINE_START,
    input wire logic FIELD_NUM,
    input wire logic STREAM_VALID,
    input wire logic LEGACY_SYNC_OUT,
    input wire logic LEGACY_SYNC_OE,
    // pixel stream in
    input wire logic PIX_VALID,
    input wire logic [11:0] PIX_X,
    input wire logic [11:0] PIX_LINE,
    input wire logic [1:0] COMP_SEL,
    input wire logic [7:0] IMG_SAMPLE,
    input wire logic [7:0] OVL_Y,
    input wire logic [7:0] OVL_U,
    input wire logic [7:0] OVL_V,
    input wire logic OVL_ALPHA_BIT,
    // pixel stream out
    output logic OUT_VALID,
    output logic [7:0] OUT_DATA,
    // frame sync pin
    input wire logic FRAME_SYNC_PIN_IN,
    output logic FRAME_SYNC_PIN_OUT,
    output logic FRAME_SYNC_PIN_OE,
    output logic GENLOCK_ACTIVE,
    // fetch engine addresses
    output logic [31:0] LUMA_PTR,
    output logic [31:0] CB_PTR,
    output logic [31:0] CR_PTR,
    output logic [31:0] OVL_PTR,
    output logic [31:0] BUF1_START,
    output logic [31:0] BUF2_START,
    output logic [23:0] BUF1_LEN,
    output logic [23:0] BUF2_LEN
);

    // byte-enable merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // mix two samples with a weight of 0 to 256 on the overlay
    function automatic logic [7:0] blend(input logic [7:0] img,
            input logic [7:0] ovl, input logic [8:0] w);
        logic [16:0] s;
        s = 17'(ovl * w) + 17'(img * (W_FULL - w));
        return s[15:8];
    endfunction : blend

    // force a sample into lo..hi, both bounds inclusive
    function automatic logic [7:0] clip(input logic [7:0] v,
            input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] r;
        r = v;
        if (v <= lo) begin
            r = lo;
        end else if (v >= hi) begin
            r = hi;
        end
        return r;
    endfunction : clip

    // register file
    logic [31:0] origin_reg, size_reg, addr1_reg, addr2_reg;
    logic [31:0] addr3_reg, ovl_addr_reg, cpitch_reg, lpitch_reg;
    logic [31:0] mask_reg, key_reg, limits_reg;
    logic [CTL_W-1:0] ctl_reg;
    logic ack_reg; // second cycle of a bus request
    logic [31:0] rdata_reg; // read data, stands when wait drops
    logic [1:0] mode_reg; // mode caught at field start

    // bus handshake: every access waits exactly one cycle
    wire req = AVS_READ | AVS_WRITE;
    wire ack_next = req & ~ack_reg;
    wire wr_fire = AVS_WRITE & ack_reg;
    assign AVS_WAITREQUEST = req & ~ack_reg;
    assign AVS_READDATA = rdata_reg;

    // control decode
    wire en = ctl_reg[CTL_EN];
    wire full_on = en & ctl_reg[CTL_FULL];
    wire custom_on = en & ctl_reg[CTL_CLIP];
    wire key_on = en & ctl_reg[CTL_KEY];
    wire field_on = en & ctl_reg[CTL_FIELD];
    wire stream_on = en & ctl_reg[CTL_STREAM] & (mode_reg == MODE_STREAM);
    wire genlock_on = en & ctl_reg[CTL_GENLOCK] & ~SYNC_MASTER;
    wire refresh = (XFER_MODE == MODE_REFRESH);
    wire streaming = (XFER_MODE == MODE_STREAM);

    // read mux; unmapped words read as zero
    logic [31:0] rd_mux;
    always_comb begin
        case (AVS_ADDRESS)
            IDX_ORIGIN: rd_mux = origin_reg;
            IDX_SIZE: rd_mux = size_reg;
            IDX_ADDR1: rd_mux = addr1_reg;
            IDX_ADDR2: rd_mux = addr2_reg;
            IDX_ADDR3: rd_mux = addr3_reg;
            IDX_OVL_ADDR: rd_mux = ovl_addr_reg;
            IDX_CHROMA_PITCH: rd_mux = cpitch_reg;
            IDX_LUMA_PITCH: rd_mux = lpitch_reg;
            IDX_CTL: rd_mux = {REVISION, 21'h0, ctl_reg};
            IDX_MASK: rd_mux = mask_reg;
            IDX_KEY: rd_mux = key_reg;
            IDX_LIMITS: rd_mux = limits_reg;
            default: rd_mux = ZERO32;
        endcase
    end

    // bus handshake and read capture
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ack_reg <= 1'b0;
            rdata_reg <= ZERO32;
        end else begin
            ack_reg <= ack_next;
            if (AVS_READ && !ack_reg) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // register writes, taken only on the edge after the wait has dropped
    wire [31:0] wm = AVS_WRITEDATA;
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            origin_reg <= ZERO32;
            size_reg <= ZERO32;
            addr1_reg <= ZERO32;
            addr2_reg <= ZERO32;
            addr3_reg <= ZERO32;
            ovl_addr_reg <= ZERO32;
            cpitch_reg <= ZERO32;
            lpitch_reg <= ZERO32;
            ctl_reg <= '0;
            mask_reg <= ZERO32;
            key_reg <= ZERO32;
            limits_reg <= LIMITS_RST;
        end else if (wr_fire) begin
            case (AVS_ADDRESS)
                IDX_ORIGIN: origin_reg <= merge(origin_reg, wm,
                    AVS_BYTEENABLE);
                IDX_SIZE: size_reg <= merge(size_reg, wm, AVS_BYTEENABLE);
                IDX_ADDR1: addr1_reg <= merge(addr1_reg, wm, AVS_BYTEENABLE);
                IDX_ADDR2: addr2_reg <= merge(addr2_reg, wm, AVS_BYTEENABLE);
                IDX_ADDR3: addr3_reg <= merge(addr3_reg, wm, AVS_BYTEENABLE);
                IDX_OVL_ADDR: ovl_addr_reg <= merge(ovl_addr_reg, wm,
                    AVS_BYTEENABLE);
                IDX_CHROMA_PITCH: cpitch_reg <= merge(cpitch_reg, wm,
                    AVS_BYTEENABLE);
                IDX_LUMA_PITCH: lpitch_reg <= merge(lpitch_reg, wm,
                    AVS_BYTEENABLE);
                // only the low control bits are writable
                IDX_CTL: begin
                    if (AVS_BYTEENABLE[0]) begin
                        ctl_reg <= wm[CTL_W-1:0];
                    end
                end
                IDX_MASK: mask_reg <= merge(mask_reg, wm, AVS_BYTEENABLE);
                IDX_KEY: key_reg <= merge(key_reg, wm, AVS_BYTEENABLE);
                IDX_LIMITS: limits_reg <= merge(limits_reg, wm,
                    AVS_BYTEENABLE);
                default: ; // unmapped: write ignored
            endcase
        end
    end

    // pointer stepping: pitches are 16-bit unsigned byte counts
    wire [31:0] luma_step = 32'(lpitch_reg[PITCH_W-1:0]);
    wire [31:0] ovl_step = 32'(lpitch_reg[HI_LSB +: PITCH_W]);
    wire [31:0] cb_step = 32'(cpitch_reg[PITCH_W-1:0]);
    wire [31:0] cr_step = 32'(cpitch_reg[HI_LSB +: PITCH_W]);

    // field start samples addresses per mode; line start steps the four pointers in refresh mode.
    // sampling only at field start keeps a field consistent even if
    // software rewrites an address mid-field
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_reg <= MODE_REFRESH;
            LUMA_PTR <= ZERO32;
            CB_PTR <= ZERO32;
            CR_PTR <= ZERO32;
            OVL_PTR <= ZERO32;
            BUF1_START <= ZERO32;
            BUF2_START <= ZERO32;
            BUF1_LEN <= '0;
            BUF2_LEN <= '0;
        end else if (FIELD_START) begin
            mode_reg <= XFER_MODE;
            LUMA_PTR <= refresh ? addr1_reg : ZERO32;
            CB_PTR <= refresh ? addr2_reg : ZERO32;
            CR_PTR <= refresh ? addr3_reg : ZERO32;
            OVL_PTR <= refresh ? ovl_addr_reg : ZERO32;
            BUF1_START <= refresh ? ZERO32 : addr1_reg;
            BUF2_START <= streaming ? addr2_reg : ZERO32;
            BUF1_LEN <= refresh ? '0 : addr3_reg[LEN_W-1:0];
            BUF2_LEN <= streaming ? ovl_addr_reg[LEN_W-1:0] : '0;
        end else if (LINE_START && mode_reg == MODE_REFRESH) begin
            LUMA_PTR <= LUMA_PTR + luma_step;
            CB_PTR <= CB_PTR + cb_step;
            CR_PTR <= CR_PTR + cr_step;
            OVL_PTR <= OVL_PTR + ovl_step;
        end
    end

    // overlay window; software keeps height and width sane
    wire [11:0] ox = origin_reg[POS_LSB +: POS_W];
    wire [11:0] oy = origin_reg[LINE_LSB +: POS_W];
    wire [11:0] ow = size_reg[POS_LSB +: POS_W];
    wire [11:0] oh = size_reg[LINE_LSB +: POS_W];
    wire in_x = (PIX_X >= ox) && ({1'b0, PIX_X} < {1'b0, ox} + {1'b0, ow});
    wire in_y = (PIX_LINE >= oy)
        && ({1'b0, PIX_LINE} < {1'b0, oy} + {1'b0, oh});
    wire ovl_hit = in_x & in_y;

    // alpha choice by the per-pixel bit
    wire [7:0] alpha = OVL_ALPHA_BIT ? origin_reg[ALPHA_LSB +: 8]
        : size_reg[ALPHA_LSB +: 8];
    // coarse: nearest of 0,25,50,75,100 percent
    wire [8:0] lvl = ({1'b0, alpha} + W_ROUND) >> 6;
    wire [8:0] w_coarse = lvl << 6;
    // fine: 255 maps to a full 256 weight
    wire [8:0] w_fine = {1'b0, alpha} + {8'h0, alpha[7]};

    // chroma key, low bits dropped by the masks
    wire [7:0] my = {4'h0, mask_reg[B0 +: 4]};
    wire [7:0] muv = {4'h0, mask_reg[CHROMA_COMPARE_MASK_LSB +: 4]};
    wire key_hit = key_on
        && ((OVL_Y & ~my) == (key_reg[B0 +: 8] & ~my))
        && ((OVL_U & ~muv) == (key_reg[B1 +: 8] & ~muv))
        && ((OVL_V & ~muv) == (key_reg[B2 +: 8] & ~muv));

    // final weight: key match leaves only the image
    wire [8:0] weight = (!ovl_hit || key_hit) ? 9'h000
        : (full_on ? w_fine : w_coarse);

    // overlay component matching the image sample
    wire [7:0] ovl_comp = (COMP_SEL == COMP_Y) ? OVL_Y
        : (COMP_SEL[1] ? OVL_V : OVL_U);
    wire [7:0] mixed = blend(IMG_SAMPLE, ovl_comp, weight);

    // limits: programmable only when enhanced and custom bit set
    wire is_y = (COMP_SEL == COMP_Y);
    wire [7:0] lo = !custom_on ? DEF_LO
        : (is_y ? limits_reg[B0 +: 8] : limits_reg[B2 +: 8]);
    wire [7:0] hi = !custom_on ? DEF_HI
        : (is_y ? limits_reg[B1 +: 8] : limits_reg[B3 +: 8]);

    // output sample register
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            OUT_VALID <= 1'b0;
            OUT_DATA <= 8'h00;
        end else begin
            OUT_VALID <= PIX_VALID;
            if (PIX_VALID) begin
                OUT_DATA <= clip(mixed, lo, hi);
            end
        end
    end

    // frame sync pin: genlock listens, then qualifier, then parity.
    // the pin input itself is used by the timing logic elsewhere
    logic pin_out_next, pin_oe_next;
    always_comb begin
        pin_out_next = LEGACY_SYNC_OUT;
        pin_oe_next = LEGACY_SYNC_OE;
        if (genlock_on) begin
            pin_out_next = 1'b0;
            pin_oe_next = 1'b0;
        end else if (stream_on) begin
            pin_out_next = STREAM_VALID;
            pin_oe_next = 1'b1;
        end else if (field_on) begin
            pin_out_next = FIELD_NUM;
            pin_oe_next = 1'b1;
        end
    end

    // pin and genlock status registers
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            FRAME_SYNC_PIN_OUT <= 1'b0;
            FRAME_SYNC_PIN_OE <= 1'b0;
            GENLOCK_ACTIVE <= 1'b0;
        end else begin
            FRAME_SYNC_PIN_OUT <= pin_out_next;
            FRAME_SYNC_PIN_OE <= pin_oe_next;
            GENLOCK_ACTIVE <= genlock_on;
        end
    end

    // checks on the logic above
    sequence s_fld;
        FIELD_START ##1 !FIELD_START;
    endsequence

    property p_rst_off;
        @(posedge SYS_CLK) $rose(RESETN) |-> ctl_reg == '0;
    endproperty
    a_rst_off: assert property (p_rst_off)
        else $error("enhancements not off after reset");

    property p_legacy;
        @(posedge SYS_CLK) disable iff (!RESETN)
        !en |=> FRAME_SYNC_PIN_OUT == $past(LEGACY_SYNC_OUT)
            && FRAME_SYNC_PIN_OE == $past(LEGACY_SYNC_OE);
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("sync pin not legacy when disabled");

    property p_field;
        @(posedge SYS_CLK) disable iff (!RESETN)
        field_on && !genlock_on && !stream_on
            |=> FRAME_SYNC_PIN_OE && FRAME_SYNC_PIN_OUT == $past(FIELD_NUM);
    endproperty
    a_field: assert property (p_field)
        else $error("sync pin does not follow field");

    property p_stream;
        @(posedge SYS_CLK) disable iff (!RESETN)
        stream_on && !genlock_on
            |=> FRAME_SYNC_PIN_OUT == $past(STREAM_VALID);
    endproperty
    a_stream: assert property (p_stream)
        else $error("sync pin not data valid");

    property p_genlock;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (en && ctl_reg[CTL_GENLOCK] && !SYNC_MASTER)
            |=> GENLOCK_ACTIVE && !FRAME_SYNC_PIN_OE;
    endproperty
    a_genlock: assert property (p_genlock)
        else $error("genlock not entered");

    property p_step;
        @(posedge SYS_CLK) disable iff (!RESETN)
        LINE_START && !FIELD_START && mode_reg == MODE_REFRESH
            |=> LUMA_PTR == $past(LUMA_PTR) + $past(luma_step)
            && OVL_PTR == $past(OVL_PTR) + $past(ovl_step);
    endproperty
    a_step: assert property (p_step)
        else $error("pointer step wrong");

    property p_load;
        @(posedge SYS_CLK) disable iff (!RESETN)
        s_fld |-> BUF1_START == (mode_reg == MODE_REFRESH ? ZERO32
            : $past(addr1_reg));
    endproperty
    a_load: assert property (p_load)
        else $error("buffer start not sampled per mode");

    property p_clip;
        @(posedge SYS_CLK) disable iff (!RESETN)
        PIX_VALID && !custom_on
            |=> OUT_DATA >= DEF_LO && OUT_DATA <= DEF_HI;
    endproperty
    a_clip: assert property (p_clip)
        else $error("fixed limits not applied");

    property p_key;
        @(posedge SYS_CLK) disable iff (!RESETN)
        PIX_VALID && key_hit && !custom_on
            && IMG_SAMPLE > DEF_LO && IMG_SAMPLE < DEF_HI
            |=> OUT_DATA == $past(IMG_SAMPLE);
    endproperty
    a_key: assert property (p_key)
        else $error("keyed overlay pixel not transparent");

    property p_rev;
        @(posedge SYS_CLK) disable iff (!RESETN)
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == IDX_CTL
            |-> AVS_READDATA[REV_LSB +: 4] == REVISION;
    endproperty
    a_rev: assert property (p_rev)
        else $error("revision field wrong");

endmodule : video_out_overlay_buffer_control
`default_nettype wire

// *** video_encoder_model.sv ***
// encoder-side model that takes in the block's pixel stream
`timescale 1ns/1ns
`default_nettype none
module video_encoder_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pixel stream from the block
    input wire logic valid,
    input wire logic [7:0] data,
    // what the encoder took in
    output logic [7:0] got_data,
    output logic [15:0] got_count
);
    // latch each sample on its valid cycle only, as an encoder would
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            got_data <= 8'h00;
            got_count <= 16'h0000;
        end else if (valid) begin
            got_data <= data;
            got_count <= got_count + 16'h0001;
        end
    end
endmodule : video_encoder_model
`default_nettype wire

// *** video_out_overlay_buffer_control_tb.sv ***
// self-checking bench for the overlay and buffer control block
`timescale 1ns/1ns
`default_nettype none
module video_out_overlay_buffer_control_tb import video_out_overlay_pkg::*;;
    // design inputs
    logic SYS_CLK, RESETN, AVS_READ, AVS_WRITE, SYNC_MASTER, FIELD_START;
    logic LINE_START, FIELD_NUM, PIX_VALID, OVL_ALPHA_BIT, STREAM_VALID;
    logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE;
    logic [31:0] AVS_WRITEDATA;
    logic [1:0] XFER_MODE, COMP_SEL;
    logic [11:0] PIX_X;
    logic [7:0] IMG_SAMPLE, OVL_Y, OVL_U, OVL_V;
    // design outputs
    logic [31:0] AVS_READDATA, LUMA_PTR, CB_PTR, CR_PTR, OVL_PTR;
    logic [31:0] BUF1_START, BUF2_START;
    logic [23:0] BUF1_LEN, BUF2_LEN;
    logic AVS_WAITREQUEST, OUT_VALID, FRAME_SYNC_PIN_OUT;
    logic FRAME_SYNC_PIN_OE, GENLOCK_ACTIVE;
    logic [7:0] OUT_DATA, got_data;
    logic [15:0] got_count;
    int mismatches = 0;
    int samples_checked = 0;
    // pins the encoder side never drives are tied
    video_out_overlay_buffer_control video_out_overlay_buffer_control_inst (
        .SYS_CLK, .RESETN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
        .XFER_MODE, .SYNC_MASTER, .FIELD_START, .LINE_START, .FIELD_NUM,
        .STREAM_VALID, .LEGACY_SYNC_OUT(1'b0), .LEGACY_SYNC_OE(1'b0),
        .PIX_VALID, .PIX_X, .PIX_LINE(12'h000), .COMP_SEL, .IMG_SAMPLE,
        .OVL_Y, .OVL_U, .OVL_V, .OVL_ALPHA_BIT, .OUT_VALID, .OUT_DATA,
        .FRAME_SYNC_PIN_IN(1'b0), .FRAME_SYNC_PIN_OUT, .FRAME_SYNC_PIN_OE,
        .GENLOCK_ACTIVE, .LUMA_PTR, .CB_PTR, .CR_PTR, .OVL_PTR,
        .BUF1_START, .BUF2_START, .BUF1_LEN, .BUF2_LEN
    );
    video_encoder_model video_encoder_model_inst (
        .clk(SYS_CLK), .rst_n(RESETN), .valid(OUT_VALID), .data(OUT_DATA),
        .got_data, .got_count
    );
    // 50 MHz system clock
    initial begin
        SYS_CLK = 1'b0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    // verdict and end of run
    task automatic summarize();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask : tick
    // one bus cycle, held until wait drops; one idle edge after release
    task automatic bus(input logic w, input logic [3:0] a,
            input logic [31:0] d, input logic [3:0] be,
            output logic [31:0] q);
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        @(posedge SYS_CLK);
        while (AVS_WAITREQUEST !== 1'b0) begin
            @(posedge SYS_CLK);
        end
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge SYS_CLK);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
        tick(2);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e,
            input string nm);
        logic [31:0] q;
        bus(1'b0, a, ZERO32, 4'hF, q);
        chk(nm, e, q);
    endtask : rd
    // field start (1) or line start (0) strobe, then let pointers settle
    task automatic strobe(input logic field);
        FIELD_START <= field;
        LINE_START <= !field;
        @(posedge SYS_CLK);
        FIELD_START <= 1'b0;
        LINE_START <= 1'b0;
        tick(2);
    endtask : strobe
    // one luma or chroma sample; result judged at the encoder model
    task automatic pix(input logic [11:0] x, input logic [1:0] c,
            input logic [7:0] img, input logic [7:0] oy, input logic ab,
            input logic [7:0] e);
        PIX_VALID <= 1'b1;
        PIX_X <= x;
        COMP_SEL <= c;
        IMG_SAMPLE <= img;
        OVL_Y <= oy;
        OVL_ALPHA_BIT <= ab;
        @(posedge SYS_CLK);
        PIX_VALID <= 1'b0;
        @(posedge SYS_CLK);
        chk("OUT_VALID", 1'b1, OUT_VALID);
        @(posedge SYS_CLK);
        chk("pixel", e, got_data);
    endtask : pix
    task automatic t_regs();
        logic [31:0] q;
        rd(IDX_CTL, 32'h3000_0000, "ctl");
        rd(IDX_LIMITS, LIMITS_RST, "limits");
        wr(IDX_CTL, 32'h0000_007F);
        rd(IDX_CTL, 32'h3000_007F, "ctl");
        wr(IDX_CTL, ZERO32);
        bus(1'b1, IDX_ADDR1, 32'hFFFF_FFFF, 4'h3, q);
        rd(IDX_ADDR1, 32'h0000_FFFF, "addr1");
        wr(4'hF, 32'h1234_5678);
        rd(4'hF, ZERO32, "unmapped");
    endtask : t_regs
    task automatic t_pointers();
        wr(IDX_ADDR1, 32'h0001_0000);
        wr(IDX_ADDR2, 32'h0002_0000);
        wr(IDX_ADDR3, 32'h0003_1040);
        wr(IDX_OVL_ADDR, 32'h0004_0000);
        wr(IDX_CHROMA_PITCH, 32'h0020_0010);
        wr(IDX_LUMA_PITCH, 32'h0100_0280);
        strobe(1'b1);
        chk("LUMA_PTR", 32'h0001_0000, LUMA_PTR);
        chk("CR_PTR", 32'h0003_1040, CR_PTR);
        strobe(1'b0);
        chk("LUMA_PTR", 32'h0001_0280, LUMA_PTR);
        chk("CB_PTR", 32'h0002_0010, CB_PTR);
        chk("CR_PTR", 32'h0003_1060, CR_PTR);
        chk("OVL_PTR", 32'h0004_0100, OVL_PTR);
        XFER_MODE <= MODE_STREAM;
        strobe(1'b1);
        chk("BUF1_LEN", 32'h0003_1040, BUF1_LEN);
        chk("BUF2_START", 32'h0002_0000, BUF2_START);
        chk("BUF2_LEN", 32'h0004_0000, BUF2_LEN);
        XFER_MODE <= MODE_MESSAGE;
        strobe(1'b1);
        chk("BUF1_START", 32'h0001_0000, BUF1_START);
        chk("BUF2_LEN", ZERO32, BUF2_LEN);
    endtask : t_pointers
    // qualifier outranks parity, parity follows field, genlock gating
    task automatic t_sync();
        XFER_MODE <= MODE_STREAM;
        strobe(1'b1);
        STREAM_VALID <= 1'b1;
        wr(IDX_CTL, 32'h0000_0019);
        chk("sync pin", 1'b1, FRAME_SYNC_PIN_OUT);
        STREAM_VALID <= 1'b0;
        tick(3);
        chk("sync pin", 1'b0, FRAME_SYNC_PIN_OUT);
        wr(IDX_CTL, 32'h0000_0011);
        FIELD_NUM <= 1'b1;
        tick(3);
        chk("sync pin", 1'b1, FRAME_SYNC_PIN_OUT);
        chk("sync pin enable", 1'b1, FRAME_SYNC_PIN_OE);
        FIELD_NUM <= 1'b0;
        tick(3);
        chk("sync pin", 1'b0, FRAME_SYNC_PIN_OUT);
        wr(IDX_CTL, 32'h0000_0021);
        chk("GENLOCK_ACTIVE", 1'b1, GENLOCK_ACTIVE);
        SYNC_MASTER <= 1'b1;
        tick(3);
        chk("GENLOCK_ACTIVE", 1'b0, GENLOCK_ACTIVE);
        SYNC_MASTER <= 1'b0;
        wr(IDX_CTL, 32'h0000_0020);
        chk("GENLOCK_ACTIVE", 1'b0, GENLOCK_ACTIVE);
    endtask : t_sync
    // empty overlay window, so only clipping acts on the image sample
    task automatic t_clip();
        wr(IDX_CTL, ZERO32);
        pix(12'h000, COMP_Y, 8'hFF, 8'h00, 1'b0, DEF_HI);
        pix(12'h000, COMP_Y, 8'h05, 8'h00, 1'b0, DEF_LO);
        wr(IDX_CTL, 32'h0000_0005);
        pix(12'h000, COMP_Y, 8'hFF, 8'h00, 1'b0, 8'hEB);
        pix(12'h000, 2'h1, 8'hFF, 8'h00, 1'b0, 8'hF0);
        wr(IDX_LIMITS, 32'hF010_C020);
        pix(12'h000, COMP_Y, 8'h18, 8'h00, 1'b0, 8'h20);
        pix(12'h000, COMP_Y, 8'hD0, 8'h00, 1'b0, 8'hC0);
        wr(IDX_CTL, 32'h0000_0004);
        pix(12'h000, COMP_Y, 8'hD0, 8'h00, 1'b0, 8'hD0);
    endtask : t_clip
    // window at pixels 2..3 of line 0
    task automatic t_overlay();
        wr(IDX_CTL, ZERO32);
        wr(IDX_ORIGIN, 32'hFF00_0002);
        wr(IDX_SIZE, 32'h0000_1002);
        pix(12'h002, COMP_Y, 8'h40, 8'h80, 1'b1, 8'h80);
        pix(12'h003, COMP_Y, 8'h40, 8'h80, 1'b0, 8'h40);
        pix(12'h001, COMP_Y, 8'h40, 8'h80, 1'b1, 8'h40);
        pix(12'h004, COMP_Y, 8'h40, 8'h80, 1'b1, 8'h40);
        wr(IDX_ORIGIN, 32'h5000_0002);
        pix(12'h002, COMP_Y, 8'h40, 8'h80, 1'b1, 8'h50);
        wr(IDX_CTL, 32'h0000_0003);
        pix(12'h002, COMP_Y, 8'h40, 8'h80, 1'b1, 8'h54);
        wr(IDX_ORIGIN, 32'hFF00_0002);
        wr(IDX_KEY, 32'h0080_8080);
        wr(IDX_MASK, 32'h0000_000F);
        wr(IDX_CTL, 32'h0000_0040);
        pix(12'h002, COMP_Y, 8'h40, 8'h8F, 1'b1, 8'h8F);
        wr(IDX_CTL, 32'h0000_0041);
        pix(12'h002, COMP_Y, 8'h40, 8'h8F, 1'b1, 8'h40);
        wr(IDX_MASK, ZERO32);
        pix(12'h002, COMP_Y, 8'h40, 8'h8F, 1'b1, 8'h8F);
        chk("got_count", 32'h0000_0010, got_count);
    endtask : t_overlay
    // main sequence
    initial begin
        RESETN = 1'b0;
        {AVS_READ, AVS_WRITE, SYNC_MASTER, FIELD_START} = 4'h0;
        {LINE_START, FIELD_NUM, PIX_VALID, OVL_ALPHA_BIT, STREAM_VALID} = '0;
        {AVS_ADDRESS, AVS_BYTEENABLE, AVS_WRITEDATA} = 40'h0;
        {XFER_MODE, COMP_SEL, PIX_X} = 16'h0000;
        {IMG_SAMPLE, OVL_Y} = 16'h0000;
        OVL_U = 8'h80;
        OVL_V = 8'h80;
        repeat (4) @(posedge SYS_CLK);
        RESETN <= 1'b1;
        @(posedge SYS_CLK);
        t_regs();
        t_pointers();
        t_sync();
        t_clip();
        t_overlay();
        summarize();
    end
    // watchdog well past the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        mismatches++;
        summarize();
    end
endmodule : video_out_overlay_buffer_control_tb
`default_nettype wire
